//--- verilog/osc_top.v
// OTP security controller: boot load, programming ports and access gating
`include "osc_consts.vh"
module osc_top (
  input wire SYS_CLK,
  input wire SYS_RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire JTAG_OTP_REQ,
  input wire JTAG_OTP_WRITE,
  input wire [`OSC_ADDR_W-1:0] JTAG_OTP_ADDR,
  input wire [31:0] JTAG_OTP_WDATA,
  output reg JTAG_OTP_ACK,
  output reg JTAG_OTP_DENY,
  output reg [31:0] JTAG_OTP_RDATA,
  output reg JTAG_ENABLE,
  input wire LINK_REQ,
  output reg LINK_GRANT,
  output reg LINK_REFUSE,
  input wire DEBUG_N_IN,
  input wire DEBUG_BREAK,
  output reg DEBUG_N_OUT,
  output reg DEBUG_N_OE,
  output reg DEBUG_ENTER,
  output reg SECURE_BOOT,
  output reg REDUNDANT_ROWS_EN,
  output reg [9:0] USER_IDENTIFIER_FIELD,
  output reg SRAM_WE,
  output reg [`OSC_SRAM_W-1:0] SRAM_ADDR,
  output reg [31:0] SRAM_WDATA,
  output reg CORE_RUN
);
  // ==========================================================
  // States
  localparam ST_LOAD = 4'h0;
  localparam ST_LOADW = 4'h1;
  localparam ST_SIZE = 4'h2;
  localparam ST_SIZEW = 4'h3;
  localparam ST_CRD = 4'h4;
  localparam ST_CWR = 4'h5;
  localparam ST_IDLE = 4'h6;
  localparam ST_CPUW = 4'h7;
  localparam ST_JTGW = 4'h8;

  // ==========================================================
  // Lock decode, shared by processor and boundary-scan paths
  function prog_locked;
    input [31:0] sec;
    input [`OSC_ADDR_W-1:0] row;
    input whole_sec;
    begin
      if (sec[`OSC_SEC_MLOCK]) begin
        prog_locked = 1'b1;
      end else if (whole_sec) begin
        prog_locked = 1'b0;
      end else begin
        prog_locked = sec[`OSC_SEC_LOCK0 + row[`OSC_SECTOR_HI:`OSC_SECTOR_LO]];
      end
    end
  endfunction

  // ==========================================================
  // State
  reg [3:0] state;
  reg [31:0] sec_cfg;
  reg [15:0] addr_port;
  reg [31:0] data_port;
  reg [15:0] ctrl_port;
  reg [31:0] read_data;
  reg busy;
  reg done;
  reg locked_ref;
  reg loaded;
  reg booted;
  reg cmd_ref;
  reg [`OSC_ADDR_W-1:0] copy_ptr;
  reg [`OSC_ADDR_W-1:0] copy_len;
  reg [2:0] dbg_sync;
  reg dbg_level;
  reg arr_rd;
  reg arr_rd_sec;
  reg arr_wr;
  reg arr_wr_sec;
  reg [`OSC_ADDR_W-1:0] arr_addr;
  reg [31:0] arr_wdata;
  wire [31:0] arr_rdata;
  wire apb_setup;
  wire apb_write;
  wire [31:0] status_word;
  wire cpu_start;
  wire [1:0] cpu_op;
  wire [`OSC_ADDR_W-1:0] cpu_row;
  wire cpu_lock;
  wire jtag_ok;
  wire jtag_lock;
  wire stat_clr;

  assign apb_setup = PSEL & ~PENABLE;
  assign apb_write = PSEL & PENABLE & PREADY & PWRITE;
  assign cpu_start = apb_write & (PADDR == `OSC_OFF_CTRL);
  assign cpu_op = PWDATA[1:0];
  assign cpu_row = addr_port[`OSC_ADDR_W-1:0];
  assign cpu_lock = prog_locked(sec_cfg, cpu_row, cpu_op == `OSC_OP_PSEC);
  // Gated by the registered enable so the port never answers while it reads as closed
  assign jtag_ok = JTAG_ENABLE & ~sec_cfg[`OSC_SEC_NOJOTP];
  assign jtag_lock = prog_locked(sec_cfg, JTAG_OTP_ADDR, 1'b0);
  assign stat_clr = apb_write & (PADDR == `OSC_OFF_STAT);
  assign status_word = {26'h0000000, cmd_ref, booted, loaded, locked_ref, done, busy};

  // ==========================================================
  // Array
  osc_array u_array (
    .clk(SYS_CLK),
    .rd_en(arr_rd),
    .rd_sec(arr_rd_sec),
    .wr_en(arr_wr),
    .wr_sec(arr_wr_sec),
    .addr(arr_addr),
    .wdata(arr_wdata),
    .rdata(arr_rdata)
  );

  // Array strobes come straight from state and the current request
  always @* begin
    arr_rd = 1'b0;
    arr_rd_sec = 1'b0;
    arr_wr = 1'b0;
    arr_wr_sec = 1'b0;
    arr_addr = cpu_row;
    arr_wdata = data_port;
    case (state)
      ST_LOAD: begin
        arr_rd_sec = 1'b1;
      end
      ST_SIZE: begin
        arr_rd = 1'b1;
        arr_addr = `OSC_ROW_ZERO;
      end
      ST_CRD: begin
        arr_rd = 1'b1;
        arr_addr = copy_ptr;
      end
      ST_IDLE: begin
        if (cpu_start & (cpu_op != `OSC_OP_NONE)) begin
          arr_rd = cpu_op == `OSC_OP_READ;
          arr_wr = (cpu_op == `OSC_OP_PROG) & ~cpu_lock;
          arr_wr_sec = (cpu_op == `OSC_OP_PSEC) & ~cpu_lock;
        end else if (JTAG_OTP_REQ & jtag_ok) begin
          arr_addr = JTAG_OTP_ADDR;
          arr_wdata = JTAG_OTP_WDATA;
          arr_rd = ~JTAG_OTP_WRITE;
          arr_wr = JTAG_OTP_WRITE & ~jtag_lock;
        end
      end
      default: begin
        arr_rd = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Sequencer: load, optional copy, then serve requests
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state <= ST_LOAD;
      sec_cfg <= `OSC_SEC_RESET;
      busy <= 1'b1;
      done <= 1'b0;
      locked_ref <= 1'b0;
      loaded <= 1'b0;
      booted <= 1'b0;
      cmd_ref <= 1'b0;
      read_data <= 32'h00000000;
      copy_ptr <= `OSC_ROW_ZERO;
      copy_len <= `OSC_ROW_ZERO;
      SRAM_WE <= 1'b0;
      SRAM_ADDR <= 15'h0000;
      SRAM_WDATA <= 32'h00000000;
      CORE_RUN <= 1'b0;
      JTAG_OTP_ACK <= 1'b0;
      JTAG_OTP_DENY <= 1'b0;
      JTAG_OTP_RDATA <= 32'h00000000;
    end else begin
      SRAM_WE <= 1'b0;
      JTAG_OTP_ACK <= 1'b0;
      JTAG_OTP_DENY <= 1'b0;
      // Clear by writing ones; a new event in the same cycle wins below
      if (stat_clr) begin
        done <= done & ~PWDATA[`OSC_ST_DONE];
        locked_ref <= locked_ref & ~PWDATA[`OSC_ST_LOCKED];
        cmd_ref <= cmd_ref & ~PWDATA[`OSC_ST_CMDREF];
      end
      if (cpu_start & (busy | (state != ST_IDLE) | (cpu_op == `OSC_OP_NONE))) begin
        cmd_ref <= 1'b1;
      end
      case (state)
        ST_LOAD: begin
          state <= ST_LOADW;
        end
        ST_LOADW: begin
          sec_cfg <= arr_rdata;
          loaded <= 1'b1;
          if (arr_rdata[`OSC_SEC_SBOOT]) begin
            state <= ST_SIZE;
          end else begin
            state <= ST_IDLE;
            busy <= 1'b0;
            booted <= 1'b1;
            CORE_RUN <= 1'b1;
          end
        end
        ST_SIZE: begin
          state <= ST_SIZEW;
        end
        ST_SIZEW: begin
          // Size word above the array depth is clipped, never wraps
          if (arr_rdata > {21'h000000, `OSC_MAX_ROW}) begin
            copy_len <= `OSC_MAX_ROW;
          end else begin
            copy_len <= arr_rdata[`OSC_ADDR_W-1:0];
          end
          copy_ptr <= `OSC_ROW_ONE;
          if (arr_rdata == 32'h00000000) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            booted <= 1'b1;
            CORE_RUN <= 1'b1;
          end else begin
            state <= ST_CRD;
          end
        end
        ST_CRD: begin
          state <= ST_CWR;
        end
        ST_CWR: begin
          SRAM_WE <= 1'b1;
          SRAM_ADDR <= {4'h0, copy_ptr - `OSC_ROW_ONE};
          SRAM_WDATA <= arr_rdata;
          copy_ptr <= copy_ptr + `OSC_ROW_ONE;
          if (copy_ptr == copy_len) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            booted <= 1'b1;
            CORE_RUN <= 1'b1;
          end else begin
            state <= ST_CRD;
          end
        end
        ST_IDLE: begin
          if (cpu_start & (cpu_op != `OSC_OP_NONE)) begin
            done <= 1'b1;
            if ((cpu_op != `OSC_OP_READ) & cpu_lock) begin
              locked_ref <= 1'b1;
            end
            if (cpu_op == `OSC_OP_READ) begin
              state <= ST_CPUW;
              busy <= 1'b1;
              done <= done & ~(stat_clr & PWDATA[`OSC_ST_DONE]);
            end
          end else if (JTAG_OTP_REQ) begin
            if (~jtag_ok | (JTAG_OTP_WRITE & jtag_lock)) begin
              JTAG_OTP_DENY <= 1'b1;
            end else if (JTAG_OTP_WRITE) begin
              JTAG_OTP_ACK <= 1'b1;
            end else begin
              state <= ST_JTGW;
            end
          end
        end
        ST_CPUW: begin
          read_data <= arr_rdata;
          done <= 1'b1;
          busy <= 1'b0;
          state <= ST_IDLE;
        end
        ST_JTGW: begin
          JTAG_OTP_RDATA <= arr_rdata;
          JTAG_OTP_ACK <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // Boundary-scan requests while busy are turned away, not queued
      if (JTAG_OTP_REQ & (state != ST_IDLE)) begin
        JTAG_OTP_DENY <= 1'b1;
      end
    end
  end

  // ==========================================================
  // APB slave, one wait-free access phase
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
      addr_port <= 16'h0000;
      data_port <= 32'h00000000;
      ctrl_port <= 16'h0000;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= 1'b0;
      if (apb_setup) begin
        PRDATA <= 32'h00000000;
        case (PADDR)
          `OSC_OFF_ADDR: PRDATA <= {16'h0000, addr_port};
          `OSC_OFF_DATA: PRDATA <= data_port;
          `OSC_OFF_CTRL: PRDATA <= {16'h0000, ctrl_port};
          `OSC_OFF_STAT: PRDATA <= status_word;
          `OSC_OFF_RDAT: PRDATA <= read_data;
          `OSC_OFF_SCFG: PRDATA <= sec_cfg;
          default: PSLVERR <= 1'b1;
        endcase
      end
      if (apb_write) begin
        case (PADDR)
          `OSC_OFF_ADDR: addr_port <= PWDATA[15:0];
          `OSC_OFF_DATA: data_port <= PWDATA;
          `OSC_OFF_CTRL: ctrl_port <= PWDATA[15:0];
          default: ctrl_port <= ctrl_port;
        endcase
      end
    end
  end

  // ==========================================================
  // Debug pin input: three stages, change taken when last two agree
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      dbg_sync <= 3'h7;
      dbg_level <= 1'b1;
    end else begin
      dbg_sync <= {dbg_sync[1:0], DEBUG_N_IN};
      if (dbg_sync[2] == dbg_sync[1]) begin
        dbg_level <= dbg_sync[2];
      end
    end
  end

  // ==========================================================
  // Access gating outputs, all but LINK_REFUSE and DEBUG_N_OUT held off until the load finishes
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      JTAG_ENABLE <= 1'b0;
      LINK_GRANT <= 1'b0;
      LINK_REFUSE <= 1'b0;
      DEBUG_N_OUT <= 1'b1;
      DEBUG_N_OE <= 1'b0;
      DEBUG_ENTER <= 1'b0;
      SECURE_BOOT <= 1'b0;
      REDUNDANT_ROWS_EN <= 1'b0;
      USER_IDENTIFIER_FIELD <= 10'h000;
    end else begin
      JTAG_ENABLE <= loaded & ~sec_cfg[`OSC_SEC_NOJTAG];
      LINK_GRANT <= LINK_REQ & loaded & ~sec_cfg[`OSC_SEC_NOLINK];
      LINK_REFUSE <= LINK_REQ & ~(loaded & ~sec_cfg[`OSC_SEC_NOLINK]);
      DEBUG_N_OUT <= 1'b0;
      DEBUG_N_OE <= DEBUG_BREAK & loaded & ~sec_cfg[`OSC_SEC_NODBG];
      DEBUG_ENTER <= ~dbg_level & loaded & ~sec_cfg[`OSC_SEC_NODBG];
      SECURE_BOOT <= sec_cfg[`OSC_SEC_SBOOT];
      REDUNDANT_ROWS_EN <= sec_cfg[`OSC_SEC_REDUN];
      USER_IDENTIFIER_FIELD <= sec_cfg[`OSC_SEC_UID_HI:`OSC_SEC_UID_LO];
    end
  end
endmodule // osc_top

//--- verilog/osc_consts.vh
// Constants shared by the OTP security controller files
`ifndef OSC_CONSTS_VH
`define OSC_CONSTS_VH
// ==========================================================
// Array geometry
`define OSC_ROW_W 32
`define OSC_ADDR_W 11
`define OSC_ROWS 2048
`define OSC_SECTOR_HI 10
`define OSC_SECTOR_LO 9
`define OSC_MAX_ROW 11'h7ff
`define OSC_ROW_ZERO 11'h000
`define OSC_ROW_ONE 11'h001
`define OSC_SRAM_W 15
// ==========================================================
// Processor port identifiers
`define OSC_RES_ADDR_PORT 24'h100200
`define OSC_RES_DATA_PORT 24'h200100
`define OSC_RES_CTRL_PORT 24'h100300
// ==========================================================
// APB register byte offsets
`define OSC_OFF_ADDR 12'h000
`define OSC_OFF_DATA 12'h004
`define OSC_OFF_CTRL 12'h008
`define OSC_OFF_STAT 12'h00c
`define OSC_OFF_RDAT 12'h010
`define OSC_OFF_SCFG 12'h014
// ==========================================================
// Control port operations in bits 1:0
`define OSC_OP_NONE 2'h0
`define OSC_OP_READ 2'h1
`define OSC_OP_PROG 2'h2
`define OSC_OP_PSEC 2'h3
// ==========================================================
// Status bits
`define OSC_ST_BUSY 0
`define OSC_ST_DONE 1
`define OSC_ST_LOCKED 2
`define OSC_ST_LOADED 3
`define OSC_ST_BOOTED 4
`define OSC_ST_CMDREF 5
// ==========================================================
// Security configuration bit positions
`define OSC_SEC_NOJTAG 0
`define OSC_SEC_NOLINK 1
`define OSC_SEC_SBOOT 5
`define OSC_SEC_REDUN 7
`define OSC_SEC_LOCK0 8
`define OSC_SEC_MLOCK 12
`define OSC_SEC_NOJOTP 13
`define OSC_SEC_NODBG 14
`define OSC_SEC_GP_HI 21
`define OSC_SEC_GP_LO 15
`define OSC_SEC_UID_HI 31
`define OSC_SEC_UID_LO 22
`define OSC_SEC_RESET 32'h00000000
`endif

//--- verilog/osc_array.v
// One-time-programmable row array with its security image word
`include "osc_consts.vh"
module osc_array (
  input wire clk,
  input wire rd_en,
  input wire rd_sec,
  input wire wr_en,
  input wire wr_sec,
  input wire [`OSC_ADDR_W-1:0] addr,
  input wire [`OSC_ROW_W-1:0] wdata,
  output reg [`OSC_ROW_W-1:0] rdata
);
  // ==========================================================
  // Storage
  reg [`OSC_ROW_W-1:0] mem [0:`OSC_ROWS-1];
  reg [`OSC_ROW_W-1:0] sec_image;
  integer i;

  // Blank part reads all zero
  initial begin
    for (i = 0; i < `OSC_ROWS; i = i + 1) begin
      mem[i] = `OSC_SEC_RESET;
    end
    sec_image = `OSC_SEC_RESET;
  end

  // ==========================================================
  // Programming only sets bits, like a fuse
  always @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= mem[addr] | wdata;
    end
    if (wr_sec) begin
      sec_image <= sec_image | wdata;
    end
    if (rd_sec) begin
      rdata <= sec_image;
    end else if (rd_en) begin
      rdata <= mem[addr];
    end
  end
endmodule // osc_array

//--- tb/osc_assertions.sv
// Port-level checks for the OTP security controller
module osc_assertions (
  input wire SYS_CLK,
  input wire SYS_RST,
  input wire PSEL,
  input wire PENABLE,
  input wire [11:0] PADDR,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire JTAG_OTP_REQ,
  input wire JTAG_OTP_ACK,
  input wire JTAG_OTP_DENY,
  input wire JTAG_ENABLE,
  input wire LINK_REQ,
  input wire LINK_GRANT,
  input wire LINK_REFUSE,
  input wire DEBUG_BREAK,
  input wire DEBUG_N_OUT,
  input wire DEBUG_N_OE,
  input wire SECURE_BOOT,
  input wire REDUNDANT_ROWS_EN,
  input wire [9:0] USER_IDENTIFIER_FIELD,
  input wire SRAM_WE,
  input wire CORE_RUN
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Properties
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);
  property p_ready;
    PSEL && !PENABLE |=> PREADY ##1 !PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("bad ready");
  property p_unmapped;
    PSEL && !PENABLE && PADDR > 12'h014 |=> PSLVERR && PRDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  property p_jtag_off;
    JTAG_OTP_REQ && !JTAG_ENABLE |=> JTAG_OTP_DENY && !JTAG_OTP_ACK;
  endproperty
  a_jtag_off: assert property (p_jtag_off) else $error("debug port open");
  property p_link;
    LINK_REQ |=> LINK_GRANT != LINK_REFUSE;
  endproperty
  a_link: assert property (p_link) else $error("link answer");
  property p_link_idle;
    !LINK_REQ |=> !LINK_GRANT && !LINK_REFUSE;
  endproperty
  a_link_idle: assert property (p_link_idle) else $error("stray link answer");
  property p_debug_out;
    DEBUG_N_OE |-> $past(DEBUG_BREAK) && !DEBUG_N_OUT;
  endproperty
  a_debug_out: assert property (p_debug_out) else $error("debug pin drive");
  // Config outputs only move at reset and the load after it
  property p_cfg_hold;
    CORE_RUN && $past(CORE_RUN, 2) |->
      $stable({SECURE_BOOT, REDUNDANT_ROWS_EN, USER_IDENTIFIER_FIELD, JTAG_ENABLE});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");
  property p_copy;
    SRAM_WE |-> SECURE_BOOT ##1 !SRAM_WE;
  endproperty
  a_copy: assert property (p_copy) else $error("bad boot copy");
endmodule // osc_assertions

//--- tb/osc_jtag_model.sv
// Debug-port requester that reads and writes array rows
module osc_jtag_model (
  input wire clk,
  output logic req,
  output logic wr,
  output logic [10:0] addr,
  output logic [31:0] wdata,
  input wire ack,
  input wire deny,
  input wire [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req = 1'b0;
    wr = 1'b0;
    addr = '0;
    wdata = '0;
  end
  // ==========================================
  // One request, then wait for the answer
  task automatic acc(input logic w, input logic [10:0] a, input logic [31:0] d,
                     output logic [1:0] res, output logic [31:0] q);
    int n = 0;
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    // Released lines carry junk so stale values cannot pass
    req <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    res = 2'd0;
    while (res == 2'd0 && n < 8) begin
      @(posedge clk);
      n++;
      if (ack === 1'b1) res = 2'd1;
      else if (deny === 1'b1) res = 2'd2;
    end
    q = rdata;
    @(posedge clk);
  endtask
endmodule // osc_jtag_model

//--- tb/osc_top_tb.sv
// Self-checking bench for the OTP security controller
`include "osc_consts.vh"
module osc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Signals
  logic SYS_CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic LINK_REQ = 1'b0, DEBUG_BREAK = 1'b0, pin_ext_n = 1'b1, serr;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, JTAG_OTP_WDATA, JTAG_OTP_RDATA, SRAM_WDATA;
  logic PREADY, PSLVERR, JTAG_OTP_REQ, JTAG_OTP_WRITE, JTAG_OTP_ACK, JTAG_OTP_DENY;
  logic JTAG_ENABLE, LINK_GRANT, LINK_REFUSE, DEBUG_N_OUT, DEBUG_N_OE, DEBUG_ENTER;
  logic SECURE_BOOT, REDUNDANT_ROWS_EN, SRAM_WE, CORE_RUN;
  logic [9:0] USER_IDENTIFIER_FIELD;
  logic [10:0] JTAG_OTP_ADDR;
  logic [14:0] SRAM_ADDR;
  logic [31:0] rdat, st, img, sw [0:3];
  logic [1:0] res;
  int fail_count = 0, checked = 0, cyc = 0, nw = 0;
  // Open-drain debug pin: low if either side pulls
  wire DEBUG_N_IN = ~DEBUG_N_OE & pin_ext_n;
  osc_top dut (.*);
  osc_jtag_model jt (.clk(SYS_CLK), .req(JTAG_OTP_REQ), .wr(JTAG_OTP_WRITE),
    .addr(JTAG_OTP_ADDR), .wdata(JTAG_OTP_WDATA), .ack(JTAG_OTP_ACK),
    .deny(JTAG_OTP_DENY), .rdata(JTAG_OTP_RDATA));
  always #10 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    cyc++;
    if (SRAM_WE === 1'b1) begin
      sw[SRAM_ADDR[1:0]] = SRAM_WDATA;
      nw++;
    end
    if (cyc == 6000) begin
      fail_count++;
      results;
    end
  end
  // ==========================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    // Waits for PREADY; only the bench timeout stops a hung wait
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    rdat = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic op(input logic [10:0] r, input logic [31:0] d, input logic [1:0] c);
    apb(1'b1, `OSC_OFF_ADDR, {21'h0, r});
    apb(1'b1, `OSC_OFF_DATA, d);
    apb(1'b1, `OSC_OFF_STAT, 32'h26);
    apb(1'b1, `OSC_OFF_CTRL, {30'h0, c});
    do begin
      apb(1'b0, `OSC_OFF_STAT, '0);
    end while (rdat[`OSC_ST_DONE] !== 1'b1);
    st = rdat;
  endtask
  task automatic pchk(input logic [10:0] r, input logic [31:0] d, input logic l,
                      input logic [31:0] e);
    op(r, d, `OSC_OP_PROG);
    chk("lock flag", st[`OSC_ST_LOCKED], l);
    op(r, '0, `OSC_OP_READ);
    apb(1'b0, `OSC_OFF_RDAT, '0);
    chk("row data", rdat, e);
  endtask
  task automatic jchk(input logic w, input logic [10:0] a, input logic [31:0] d,
                      input logic [1:0] er, input logic [31:0] eq);
    logic [31:0] q;
    jt.acc(w, a, d, res, q);
    chk("jtag answer", res, er);
    if (!w && er == 2'd1) chk("jtag data", q, eq);
  endtask
  task automatic rst;
    @(posedge SYS_CLK);
    SYS_RST <= 1'b1;
    repeat (8) @(posedge SYS_CLK);
    nw = 0;
    SYS_RST <= 1'b0;
    while (CORE_RUN !== 1'b1) begin
      @(posedge SYS_CLK);
    end
    repeat (3) @(posedge SYS_CLK);
  endtask
  task automatic lk(input logic g);
    LINK_REQ <= 1'b1;
    @(posedge SYS_CLK);
    LINK_REQ <= 1'b0;
    @(posedge SYS_CLK);
    chk("link grant", LINK_GRANT, g);
    chk("link refuse", LINK_REFUSE, !g);
  endtask
  task automatic dbg(input logic e);
    DEBUG_BREAK <= 1'b1;
    pin_ext_n <= 1'b0;
    repeat (6) @(posedge SYS_CLK);
    chk("debug drive", DEBUG_N_OE, e);
    chk("debug enter", DEBUG_ENTER, e);
    DEBUG_BREAK <= 1'b0;
    pin_ext_n <= 1'b1;
    repeat (6) @(posedge SYS_CLK);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    rst;
    apb(1'b0, `OSC_OFF_SCFG, '0);
    chk("config blank", rdat, `OSC_SEC_RESET);
    apb(1'b0, `OSC_OFF_STAT, '0);
    chk("status", rdat, 32'h18);
    chk("user id", USER_IDENTIFIER_FIELD, '0);
    chk("jtag on", JTAG_ENABLE, 1'b1);
    apb(1'b0, 12'h018, '0);
    chk("unmapped", {serr, rdat[30:0]}, 32'h80000000);
    apb(1'b1, `OSC_OFF_ADDR, '1);
    apb(1'b0, `OSC_OFF_ADDR, '0);
    chk("address port", rdat, 32'h0000ffff);
    apb(1'b1, `OSC_OFF_DATA, 32'ha5a55a5a);
    apb(1'b0, `OSC_OFF_DATA, '0);
    chk("data port", rdat, 32'ha5a55a5a);
    apb(1'b1, `OSC_OFF_STAT, 32'h26);
    apb(1'b1, `OSC_OFF_CTRL, {30'h0, `OSC_OP_NONE});
    apb(1'b0, `OSC_OFF_STAT, '0);
    chk("refused op", rdat, 32'h38);
    $display("test reset and ports done");
    pchk(11'd5, 32'hf0, 1'b0, 32'hf0);
    pchk(11'd5, 32'h0f, 1'b0, 32'hff);
    pchk(`OSC_MAX_ROW, 32'h80000001, 1'b0, 32'h80000001);
    pchk(11'd0, 32'h2, 1'b0, 32'h2);
    pchk(11'd1, 32'h1111, 1'b0, 32'h1111);
    pchk(11'd2, 32'h2222, 1'b0, 32'h2222);
    jchk(1'b0, 11'd5, '0, 2'd1, 32'hff);
    jchk(1'b1, 11'd600, 32'h3, 2'd1, '0);
    jchk(1'b0, 11'd600, '0, 2'd1, 32'h3);
    lk(1'b1);
    dbg(1'b1);
    $display("test programming done");
    img = 32'h45a2 | (32'h55 << 15) | (32'h2a5 << 22);
    op(11'd0, img, `OSC_OP_PSEC);
    apb(1'b0, `OSC_OFF_SCFG, '0);
    chk("config before reset", rdat, '0);
    rst;
    apb(1'b0, `OSC_OFF_SCFG, '0);
    chk("config loaded", rdat, img);
    chk("user id", USER_IDENTIFIER_FIELD, 32'h2a5);
    chk("redundant rows", REDUNDANT_ROWS_EN, 1'b1);
    chk("secure boot", SECURE_BOOT, 1'b1);
    chk("boot words", nw, 2);
    chk("boot word 0", sw[0], 32'h1111);
    chk("boot word 1", sw[1], 32'h2222);
    lk(1'b0);
    dbg(1'b0);
    // Sectors 0 and 2 locked, 1 and 3 open
    for (int s = 0; s < 4; s++) begin
      pchk(11'(s * 512 + 3), 32'h1, !s[0], {31'h0, s[0]});
    end
    jchk(1'b1, 11'd4, 32'h1, 2'd2, '0);
    jchk(1'b0, 11'd1, '0, 2'd1, 32'h1111);
    $display("test sector locks done");
    op(11'd0, 32'h3a01, `OSC_OP_PSEC);
    rst;
    chk("jtag off", JTAG_ENABLE, 1'b0);
    jchk(1'b0, 11'd1, '0, 2'd2, '0);
    for (int s = 0; s < 4; s++) begin
      pchk(11'(s * 512 + 7), 32'h1, 1'b1, '0);
    end
    // Bit 16 is clear in the image, so a leaked write would show
    op(11'd0, 32'h10000, `OSC_OP_PSEC);
    chk("image locked", st[`OSC_ST_LOCKED], 1'b1);
    rst;
    apb(1'b0, `OSC_OFF_SCFG, '0);
    chk("image kept", rdat, img | 32'h3a01);
    $display("test master lock done");
    results;
  end
endmodule // osc_top_tb
bind osc_top osc_assertions u_chk (.*);
